/* core/asp_pkg.sv */
// Constants, state codes and pin bundles for the converter serial port timing engine.
// Overview of operation
// [RULE1] Power-down low stops conversions and serial activity, clearing the digital state.
// [RULE2] Active-low result-ready output falls when a new result can be read.
// [RULE3] Data output is released at once when chip select goes high.
// [RULE4] With chip select low, output floats 6 to 10 oscillator periods after last edge.
// [RULE5] Host waits 50 oscillator periods between input bits and first output edge.
// [RULE6] Host may end a read at once; after a write holds select 8 more periods.
// [RULE7] Host waits 4 oscillator periods between commands, 16 after a reset command.
// [RULE8] Host waits 2 result periods after single calibrations, 4 after full self-calibration.
// [RULE9] In continuous-read mode host waits 10 periods after result-ready falls.
// [RULE10] Result register is invalid for 4 oscillator periods while it is updated.
// [RULE11] Host measures all waits against the device oscillator or a safe equivalent.
package asp_pkg;
  localparam int RESULT_W = 24;
  localparam int FIFO_DEPTH = 8;
  localparam int CMD_W = 8;
  // The core clock is the device oscillator.
  localparam int CLK_PERIOD_NS = 4;
  localparam int OSC_PERIOD_NS = 4;
  localparam int SYNC_LAT_CYC = 2;
  localparam int FLOAT_MIN_OSC = 6;
  localparam int FLOAT_MAX_OSC = 10;
  localparam int FLOAT_MIN_CYC = (FLOAT_MIN_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_MAX_CYC = (FLOAT_MAX_OSC * OSC_PERIOD_NS) / CLK_PERIOD_NS;
  // Counted from the detected edge, which lags the pin by the synchroniser.
  localparam int FLOAT_CYC = (FLOAT_MIN_CYC + FLOAT_MAX_CYC) / 2 - SYNC_LAT_CYC;
  localparam int UPDATE_OSC = 4;
  localparam int UPDATE_CYC = (UPDATE_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FLOAT_CNT = CNT_W'(FLOAT_CYC);
  localparam logic [CNT_W-1:0] UPDATE_CNT = CNT_W'(UPDATE_CYC);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(RESULT_W - 1);
  localparam logic [CNT_W-1:0] LAST_CMD_BIT = CNT_W'(CMD_W - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

  typedef logic [CNT_W-1:0] asp_cnt_t;
  typedef logic [RESULT_W-1:0] asp_result_t;

  typedef enum logic [1:0] {
    ASP_IDLE = 2'h0,
    ASP_UPDATE = 2'h1,
    ASP_READY = 2'h3,
    ASP_SHIFT = 2'h2
  } asp_state_e;

  typedef struct packed {
    logic power_down_n;
    logic cs_n;
    logic sclk;
    logic din;
  } asp_pins_s;

  localparam asp_pins_s PINS_IDLE = 4'hc;
endpackage

/* core/asp_fifo.sv */
// Result FIFO with valid and ready on both sides and registered full and empty.
`timescale 1ns/1ns
`default_nettype none
module asp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic flush_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ready_q, ready_d, valid_q, valid_d;
  logic push, pop;

  assign push = in_valid_i && ready_q;
  assign pop = out_ready_i && valid_q;
  assign in_ready_o = ready_q;
  assign out_valid_o = valid_q;
  assign out_data_o = mem_q[rd_q];

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
    ready_d = !flush_i && (cnt_d != (AW+1)'(DEPTH));
    valid_d = (cnt_d != '0);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
      valid_q <= valid_d;
    end
  end

  // Storage carries no reset so it maps onto plain RAM.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

/* core/asp_core.sv */
// Serial port engine: pin synchronisers, result loading, bit shifting and output release.
`timescale 1ns/1ns
`default_nettype none
module asp_core
  import asp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic power_down_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic result_ready_n_o,
  input wire asp_pkg::asp_result_t conv_data_i,
  input wire logic conv_valid_i,
  output logic conv_ready_o,
  output logic [asp_pkg::CMD_W-1:0] cmd_byte_o,
  output logic cmd_valid_o
);
  import asp_pkg::*;

  asp_pins_s pins_raw, sync1_q, sync2_q, pins_q;
  logic sclk_prev_q;
  logic sclk_rise, sclk_edge, cs_fall, active;

  asp_state_e state_q, state_d;
  asp_result_t shreg_q, shreg_d;
  asp_cnt_t bit_q, bit_d, upd_q, upd_d, float_q, float_d, cbit_q, cbit_d;
  logic [CMD_W-1:0] cmd_q, cmd_d, cmd_out_q, cmd_out_d;
  logic cmd_valid_q, cmd_valid_d;
  logic dout_q, dout_d, oe_q, oe_d, rdy_n_q, rdy_n_d, floating_q, floating_d;
  logic fifo_flush, fifo_valid, fifo_pop;
  asp_result_t fifo_data;

  assign pins_raw = '{power_down_n: power_down_n_i, cs_n: cs_n_i, sclk: sclk_i, din: din_i};

  // Every pin passes two flops; logic reads the second stage, plus one more delayed copy of select and clock for edges.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q <= PINS_IDLE;
      sync2_q <= PINS_IDLE;
      sclk_prev_q <= 1'b0;
      pins_q <= PINS_IDLE;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sclk_prev_q <= sync2_q.sclk;
      pins_q <= sync2_q;
    end
  end

  // [RULE1] power down gating
  assign active = sync2_q.power_down_n;
  assign sclk_edge = active && !sync2_q.cs_n && (sync2_q.sclk != sclk_prev_q);
  assign sclk_rise = sclk_edge && sync2_q.sclk;
  assign cs_fall = !sync2_q.cs_n && pins_q.cs_n;

  // [RULE1] FIFO flushed while powered down
  assign fifo_flush = !active;
  assign fifo_pop = (state_q == ASP_IDLE) && active && fifo_valid;

  asp_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .flush_i(fifo_flush),
    .in_data_i(conv_data_i),
    .in_valid_i(conv_valid_i),
    .in_ready_o(conv_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  // Result loading and shifting.
  always_comb begin
    state_d = state_q;
    shreg_d = shreg_q;
    bit_d = bit_q;
    upd_d = upd_q;
    rdy_n_d = rdy_n_q;
    case (state_q)
      ASP_IDLE: begin
        rdy_n_d = 1'b1;
        if (fifo_pop) begin
          shreg_d = fifo_data;
          upd_d = UPDATE_CNT - 1'b1;
          state_d = ASP_UPDATE;
        end
      end
      // [RULE10] update window hidden
      ASP_UPDATE: begin
        rdy_n_d = 1'b1;
        bit_d = CNT_ZERO;
        if (upd_q == CNT_ZERO) begin
          state_d = ASP_READY;
          // [RULE2] ready falls
          rdy_n_d = 1'b0;
        end else begin
          upd_d = upd_q - 1'b1;
        end
      end
      ASP_READY: begin
        if (sclk_rise) begin
          state_d = ASP_SHIFT;
          shreg_d = {shreg_q[RESULT_W-2:0], 1'b0};
          bit_d = bit_q + 1'b1;
        end
      end
      ASP_SHIFT: begin
        if (sclk_rise) begin
          shreg_d = {shreg_q[RESULT_W-2:0], 1'b0};
          if (bit_q == LAST_BIT) begin
            state_d = ASP_IDLE;
            rdy_n_d = 1'b1;
          end else begin
            bit_d = bit_q + 1'b1;
          end
        end
      end
      default: begin
        state_d = ASP_IDLE;
        rdy_n_d = 1'b1;
      end
    endcase
    if (!active) begin
      state_d = ASP_IDLE;
      rdy_n_d = 1'b1;
      bit_d = CNT_ZERO;
      upd_d = CNT_ZERO;
    end
  end

  // Command bits are captured on the rising edge; decoding sits downstream.
  always_comb begin
    cmd_d = cmd_q;
    cbit_d = cbit_q;
    cmd_out_d = cmd_out_q;
    cmd_valid_d = 1'b0;
    if (sync2_q.cs_n || !active) begin
      cbit_d = CNT_ZERO;
    end else if (sclk_rise) begin
      cmd_d = {cmd_q[CMD_W-2:0], sync2_q.din};
      if (cbit_q == LAST_CMD_BIT) begin
        cbit_d = CNT_ZERO;
        cmd_out_d = {cmd_q[CMD_W-2:0], sync2_q.din};
        cmd_valid_d = 1'b1;
      end else begin
        cbit_d = cbit_q + 1'b1;
      end
    end
  end

  // Output driver and release timing.
  always_comb begin
    float_d = float_q;
    floating_d = floating_q;
    dout_d = shreg_d[RESULT_W-1];
    if (sclk_edge || cs_fall) begin
      float_d = FLOAT_CNT;
      floating_d = 1'b0;
    end else if (float_q != CNT_ZERO) begin
      float_d = float_q - 1'b1;
      // [RULE4] float after idle SCLK
      if (float_q == 5'h01) begin
        floating_d = 1'b1;
      end
    end
    oe_d = !floating_d;
    // [RULE3] release on chip select high
    if (sync2_q.cs_n || !active) begin
      oe_d = 1'b0;
      floating_d = 1'b1;
      float_d = CNT_ZERO;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ASP_IDLE;
      shreg_q <= '0;
      bit_q <= CNT_ZERO;
      upd_q <= CNT_ZERO;
      rdy_n_q <= 1'b1;
      cmd_q <= '0;
      cbit_q <= CNT_ZERO;
      cmd_out_q <= '0;
      cmd_valid_q <= 1'b0;
      float_q <= CNT_ZERO;
      floating_q <= 1'b1;
      dout_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shreg_q <= shreg_d;
      bit_q <= bit_d;
      upd_q <= upd_d;
      rdy_n_q <= rdy_n_d;
      cmd_q <= cmd_d;
      cbit_q <= cbit_d;
      cmd_out_q <= cmd_out_d;
      cmd_valid_q <= cmd_valid_d;
      float_q <= float_d;
      floating_q <= floating_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
    end
  end

  assign dout_o = dout_q;
  assign dout_oe_o = oe_q;
  assign result_ready_n_o = rdy_n_q;
  assign cmd_byte_o = cmd_out_q;
  assign cmd_valid_o = cmd_valid_q;
endmodule
`default_nettype wire

/* verification/asp_core_asserts.sv */
// Timing checks on the converter serial port engine.
`timescale 1ns/1ns
`default_nettype none
module asp_core_asserts (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic power_down_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic conv_valid_i,
  input wire logic conv_ready_o,
  input wire logic dout_oe_o,
  input wire logic result_ready_n_o,
  input wire logic cmd_valid_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [3:0] idle_q, idle_d;
  logic armed_q, armed_d, sclk_q, edge_w;
  // Armed only after a serial edge inside a frame, so a fresh select is not judged.
  assign edge_w = sclk_i != sclk_q;
  always_comb begin
    idle_d = edge_w ? 4'h0 : idle_q + {3'h0, idle_q != 4'hf};
    armed_d = !cs_n_i && power_down_n_i && (edge_w || armed_q);
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {idle_q, armed_q, sclk_q} <= 6'h00;
    end else begin
      {idle_q, armed_q, sclk_q} <= {idle_d, armed_d, sclk_i};
    end
  end
  a_pd_quiet: assert property (
    !power_down_n_i [*4] |-> !dout_oe_o && result_ready_n_o && !conv_ready_o && !cmd_valid_o)
    else $error("port active while powered down");
  a_ready_follows: assert property (
    conv_valid_i && conv_ready_o && power_down_n_i && cs_n_i
    |-> ##[1:10] (!result_ready_n_o || !power_down_n_i))
    else $error("result ready did not fall after a result");
  a_cs_release: assert property (
    cs_n_i [*5] |-> !dout_oe_o)
    else $error("data output driven while deselected");
  a_float_early: assert property (
    $changed(sclk_i) && power_down_n_i && !cs_n_i
    ##1 (!cs_n_i && power_down_n_i && $stable(sclk_i)) [*4] |-> dout_oe_o)
    else $error("data output released too early");
  a_float_late: assert property (
    armed_q && idle_q >= 4'h9 |-> !dout_oe_o)
    else $error("data output not released in time");
  a_cmd_pulse: assert property (
    cmd_valid_o |=> !cmd_valid_o)
    else $error("command strobe longer than one cycle");
  c_ready_fall: cover property ($fell(result_ready_n_o));
  c_float: cover property ($fell(dout_oe_o) && !cs_n_i);
  c_full: cover property (!conv_ready_o && power_down_n_i);
endmodule
bind asp_core asp_core_asserts i_asp_core_asserts (
  .core_clk_i(core_clk_i),
  .arst_n_i(arst_n_i),
  .power_down_n_i(power_down_n_i),
  .cs_n_i(cs_n_i),
  .sclk_i(sclk_i),
  .conv_valid_i(conv_valid_i),
  .conv_ready_o(conv_ready_o),
  .dout_oe_o(dout_oe_o),
  .result_ready_n_o(result_ready_n_o),
  .cmd_valid_o(cmd_valid_o)
);
`default_nettype wire

/* verification/asp_host.sv */
// Serial master model that clocks words through the converter port.
`timescale 1ns/1ns
`default_nettype none
module asp_host (
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o,
  input wire logic dout_i,
  input wire logic dout_oe_i
);
  logic line;
  // A released output reads as the inverse, so a stale bit never passes.
  assign line = dout_oe_i ? dout_i : ~dout_i;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
    // Gap before frame.
    // The gap covers the longest spacing that a read after command bits needs.
    #200;
    cs_n_o = 1'b0;
    din_o = tx[23];
    // Leading bit taken.
    // The select fall keeps the line driven only a few periods, so look early.
    #24;
    rx = {23'h0, line};
    #38;
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b1;
      // The line floats a few periods after each edge, so sample soon after the rise.
      #24;
      if (i < n - 1) rx = {rx[22:0], line};
      #39;
      sclk_o = 1'b0;
      if (i < n - 1) begin
        din_o = tx[22-i];
        #62;
      end
    end
  endtask
  task automatic cs_up();
    cs_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

/* verification/asp_core_tb.sv */
// Self-checking bench for the converter serial port engine.
`timescale 1ns/1ns
`default_nettype none
module asp_core_tb;
  import asp_pkg::*;
  logic clk, arst_n, pd_n, cv, cr, cs_n, sclk, din, dout, oe, rdy_n, cmdv;
  asp_result_t cd;
  logic [CMD_W-1:0] cmd;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_cmdv = 0;
  asp_core i_asp_core (.core_clk_i(clk), .arst_n_i(arst_n), .power_down_n_i(pd_n),
    .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din), .dout_o(dout), .dout_oe_o(oe),
    .result_ready_n_o(rdy_n), .conv_data_i(cd), .conv_valid_i(cv), .conv_ready_o(cr),
    .cmd_byte_o(cmd), .cmd_valid_o(cmdv));
  asp_host i_asp_host (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .dout_i(dout),
    .dout_oe_i(oe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Command strobes are counted on the falling edge, clear of the launching edge.
  always @(negedge clk) begin
    if (cmdv === 1'b1) begin
      n_cmdv++;
    end
  end
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic push(input asp_result_t w, output bit ok);
    @(negedge clk);
    cd = w;
    cv = 1'b1;
    ok = (cr === 1'b1);
  endtask
  task automatic send(input asp_result_t w);
    bit ok;
    push(w, ok);
    @(negedge clk);
    cv = 1'b0;
    chk(ok, 1'b1);
  endtask
  task automatic wait_rdy();
    int i;
    // Result-period spacing.
    // Each read that starts on a new result waits for it here, which is never sooner than a result period.
    for (i = 0; i < 200 && rdy_n !== 1'b0; i++) @(negedge clk);
    if (i == 200) begin
      n_mismatch++;
      close_out();
    end
  endtask
  task automatic s_single();
    logic [23:0] rx;
    send(24'hc3a55a);
    wait_rdy();
    i_asp_host.xfer(24, 24'h0, rx);
    chk(rx, 24'hc3a55a);
    cycles(5);
    chk(oe, 1'b1);
    cycles(6);
    chk(oe, 1'b0);
    chk(rdy_n, 1'b1);
    i_asp_host.cs_up();
  endtask
  task automatic s_partial();
    logic [23:0] rx;
    send(24'h81e742);
    wait_rdy();
    i_asp_host.xfer(8, 24'ha50000, rx);
    i_asp_host.cs_up();
    chk(rx[7:0], 8'h81);
    cycles(4);
    chk(oe, 1'b0);
    chk(cmd, 8'ha5);
    chk(n_cmdv, 4);
    i_asp_host.xfer(16, 24'h0, rx);
    chk(rx[15:0], 16'he742);
    i_asp_host.cs_up();
  endtask
  task automatic s_fill();
    int n;
    bit ok;
    logic [23:0] rx;
    n = 0;
    ok = 1'b1;
    while (ok && n < 12) begin
      push({4'ha, 12'(n), 8'h5c}, ok);
      if (ok) n++;
    end
    @(negedge clk);
    cv = 1'b0;
    chk(n, 9);
    for (int i = 0; i < 9; i++) begin
      wait_rdy();
      i_asp_host.xfer(24, 24'h0, rx);
      chk(rx, {4'ha, 12'(i), 8'h5c});
      i_asp_host.cs_up();
    end
    cycles(10);
    chk({rdy_n, cr}, 2'b11);
  endtask
  task automatic s_pdown();
    logic [23:0] rx;
    int c;
    send(24'h0f0f0f);
    wait_rdy();
    pd_n = 1'b0;
    cycles(5);
    chk({rdy_n, oe, cr}, 3'b100);
    c = n_cmdv;
    i_asp_host.xfer(8, 24'hff0000, rx);
    chk(oe, 1'b0);
    chk(n_cmdv, c);
    chk(cmd, 8'h00);
    i_asp_host.cs_up();
    cycles(2);
    pd_n = 1'b1;
    cycles(20);
    chk({rdy_n, cr}, 2'b11);
  endtask
  initial begin
    arst_n = 1'b0;
    pd_n = 1'b1;
    cv = 1'b0;
    cd = 24'h0;
    cycles(5);
    arst_n = 1'b1;
    cycles(4);
    s_single();
    s_partial();
    s_fill();
    s_pdown();
    close_out();
  end
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
